// >>> core/tip_defs.vh
`ifndef TIP_DEFS_VH
`define TIP_DEFS_VH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define TIP_IDX_CTRL 16'hff88
`define TIP_IDX_MODE 16'hff89
`define TIP_IDX_TRGS 16'hff8b
`define TIP_IDX_OC 16'hff8c
`define TIP_IDX_DTIME 16'hff8d
`define TIP_IDX_STATUS 16'hff8e
`define TIP_IDX_CM0 16'hff90
`define TIP_IDX_BF0 16'hff98
`define TIP_NUM_CM 6

// ****************************************************************
// field positions
// ****************************************************************
`define TIP_CTRL_RUN 7
`define TIP_CTRL_CLK_HI 5
`define TIP_CTRL_CLK_LO 3
`define TIP_CTRL_DIV_HI 2
`define TIP_CTRL_DIV_LO 0
`define TIP_MODE_POL 3
`define TIP_STAT_DIR 10

// ****************************************************************
// reset values
// ****************************************************************
`define TIP_RST_CTRL 8'h00
`define TIP_RST_MODE 8'h00
`define TIP_RST_TRGS 8'h00
`define TIP_RST_OC 8'h00
`define TIP_RST_DTIME 8'hff
`define TIP_RST_CM 10'h000
`define TIP_RST_PERIOD 10'h3ff
`define TIP_RST_DTM 8'hff
`define TIP_RST_DIV 3'h7

// ****************************************************************
// counts and codes
// ****************************************************************
`define TIP_CLK_MAX 3'h5
`define TIP_PRE_W 5
`define TIP_TRG_NONE 2'h0
`define TIP_TRG_A 2'h1
`define TIP_TRG_B 2'h2
`define TIP_TRG_AB 2'h3
`define TIP_RESP_OKAY 2'h0
`define TIP_RESP_SLVERR 2'h2

`endif

// >>> core/tip_phase.v
`timescale 1ns/10ps
`default_nettype none
`include "tip_defs.vh"

// one phase: carrier compare, fixed-level cases and dead time
module tip_phase
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // control
  input wire run,
  input wire [9:0] cnt,
  input wire down,
  input wire [9:0] period,
  input wire [9:0] cmp,
  input wire [9:0] buf_val,
  input wire [7:0] deadtime,
  // raw outputs, true while the stage must be on
  output wire pos_on,
  output wire neg_on
);

  reg raw_q;
  reg [7:0] dtm_q;
  reg busy_q;
  reg raw_d;

  // raw level: set by the up-slope match, cleared by the down-slope match
  always @*
  begin
    if (cmp > period)
      raw_d = 1'b0;
    else if (cmp == 10'h000 && buf_val >= period)
      raw_d = 1'b1;
    else if (cmp == 10'h000)
      raw_d = 1'b0;
    else
      raw_d = down ? (cnt > cmp) : (cnt >= cmp);
  end

  // dead-time counter reloads on every flip, stops at all ones
  always @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      raw_q <= 1'b0;
      dtm_q <= `TIP_RST_DTM;
      busy_q <= 1'b0;
    end
    else
    begin
      raw_q <= raw_d;
      // reload whenever the raw level flips
      // a separate busy flag lets a reload of all ones still count 256 cycles
      if (raw_d != raw_q)
      begin
        dtm_q <= deadtime;
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        dtm_q <= dtm_q - 8'h01;
        busy_q <= (dtm_q != 8'h00);
      end
    end
  end

  assign pos_on = raw_q && !busy_q;
  assign neg_on = !raw_q && !busy_q;

endmodule

`default_nettype wire

// >>> core/tip_inverter_pwm.v
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "tip_defs.vh"

module tip_inverter_pwm
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [19:0] awaddr,
  input wire awvalid,
  output wire awready,
  // axi4-lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  // axi4-lite write response
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  // axi4-lite read
  input wire [19:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  // inverter stage
  output wire [5:0] pwm_out,
  output wire pwm_oe,
  // events
  output wire converter_trigger_out,
  output wire period_interrupt,
  output wire compare4_match_event,
  output wire compare5_match_event
);

  // ****************************************************************
  // bus slave state
  // ****************************************************************
  reg aw_full_q;
  reg w_full_q;
  reg [15:0] aw_idx_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  // ****************************************************************
  // registers and timers
  // ****************************************************************
  reg [7:0] ctrl_q;
  reg [7:0] mode_q;
  reg [7:0] trgs_q;
  reg [7:0] oc_q;
  reg [7:0] dtime_q;
  reg [59:0] cm_q;
  reg [59:0] bf_q;
  reg [4:0] pre_q;
  reg [9:0] cnt_q;
  reg down_q;
  reg step_q;
  reg [2:0] div_q;
  reg [5:0] pwm_q;
  reg pwm_oe_q;
  reg trig_q;
  reg irq_q;
  reg m4_q;
  reg m5_q;

  wire run = ctrl_q[`TIP_CTRL_RUN];
  wire [2:0] clk_sel = ctrl_q[`TIP_CTRL_CLK_HI:`TIP_CTRL_CLK_LO];
  wire [2:0] div_sel = ctrl_q[`TIP_CTRL_DIV_HI:`TIP_CTRL_DIV_LO];
  wire [9:0] period = cm_q[39:30];
  wire wr_fire = aw_full_q && w_full_q && !bvalid_q;
  wire rd_fire = arvalid && !rvalid_q;
  wire [15:0] ar_idx = araddr[17:2];
  wire wr_cm = (aw_idx_q >= `TIP_IDX_CM0) && (aw_idx_q < `TIP_IDX_CM0 + 16'h0006);
  wire wr_bf = (aw_idx_q >= `TIP_IDX_BF0) && (aw_idx_q < `TIP_IDX_BF0 + 16'h0006);
  wire [2:0] wr_sel = aw_idx_q[2:0];

  // merge a 10-bit register with byte lanes
  function [9:0] merge10;
    input [9:0] old;
    input [31:0] d;
    input [3:0] s;
    begin
      merge10 = {s[1] ? d[9:8] : old[9:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // ****************************************************************
  // axi4-lite handshakes
  // ****************************************************************
  assign awready = !aw_full_q;
  assign wready = !w_full_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // address and data are held until both are in, then answered
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_idx_q <= 16'h0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `TIP_RESP_OKAY;
    end
    else
    begin
      if (awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        aw_idx_q <= awaddr[17:2];
      end
      if (wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_cm || wr_bf || aw_idx_q == `TIP_IDX_CTRL || aw_idx_q == `TIP_IDX_MODE
          || aw_idx_q == `TIP_IDX_TRGS || aw_idx_q == `TIP_IDX_OC
          || aw_idx_q == `TIP_IDX_DTIME || aw_idx_q == `TIP_IDX_STATUS)
          ? `TIP_RESP_OKAY : `TIP_RESP_SLVERR;
      end
      else if (bready)
        bvalid_q <= 1'b0;
    end
  end

  // read data captured on the address handshake, one cycle latency
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `TIP_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= `TIP_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      if (ar_idx >= `TIP_IDX_CM0 && ar_idx < `TIP_IDX_CM0 + 16'h0006)
        rdata_q[9:0] <= cm_q[ar_idx[2:0]*10 +: 10];
      else if (ar_idx >= `TIP_IDX_BF0 && ar_idx < `TIP_IDX_BF0 + 16'h0006)
        rdata_q[9:0] <= bf_q[ar_idx[2:0]*10 +: 10];
      else if (ar_idx == `TIP_IDX_CTRL)
        rdata_q[7:0] <= ctrl_q;
      else if (ar_idx == `TIP_IDX_MODE)
        rdata_q[7:0] <= mode_q;
      else if (ar_idx == `TIP_IDX_TRGS)
        rdata_q[7:0] <= trgs_q;
      else if (ar_idx == `TIP_IDX_OC)
        rdata_q[7:0] <= oc_q;
      else if (ar_idx == `TIP_IDX_DTIME)
        rdata_q[7:0] <= dtime_q;
      else if (ar_idx == `TIP_IDX_STATUS)
        rdata_q[10:0] <= {down_q, cnt_q};
      else
        rresp_q <= `TIP_RESP_SLVERR;
    end
    else if (rready)
      rvalid_q <= 1'b0;
  end

  // ****************************************************************
  // carrier timing
  // ****************************************************************
  wire [4:0] pre_mask = (5'h01 << clk_sel) - 5'h01;
  wire pre_tick = (clk_sel <= `TIP_CLK_MAX) && ((pre_q & pre_mask) == pre_mask);
  wire underflow = pre_tick && down_q && (cnt_q == 10'h001);
  wire xfer = underflow && (div_q + 3'h1 == div_sel);

  // prescaler, up/down counter and transfer divider
  always @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      pre_q <= 5'h00;
      cnt_q <= 10'h000;
      down_q <= 1'b0;
      step_q <= 1'b0;
      div_q <= `TIP_RST_DIV;
    end
    else
    begin
      pre_q <= pre_q + 5'h01;
      step_q <= pre_tick;
      if (pre_tick)
      begin
        if (!down_q && cnt_q >= period)
        begin
          down_q <= 1'b1;
          cnt_q <= cnt_q - 10'h001;
        end
        else if (down_q && cnt_q == 10'h000)
        begin
          down_q <= 1'b0;
          cnt_q <= 10'h001;
        end
        else if (down_q)
          cnt_q <= cnt_q - 10'h001;
        else
          cnt_q <= cnt_q + 10'h001;
      end
      if (xfer)
        div_q <= `TIP_RST_DIV;
      else if (underflow)
        div_q <= div_q + 3'h1;
    end
  end

  // ****************************************************************
  // software registers and buffer transfer
  // ****************************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= `TIP_RST_CTRL;
      mode_q <= `TIP_RST_MODE;
      trgs_q <= `TIP_RST_TRGS;
      oc_q <= `TIP_RST_OC;
      dtime_q <= `TIP_RST_DTIME;
      cm_q <= {`TIP_RST_CM, `TIP_RST_CM, `TIP_RST_PERIOD, `TIP_RST_CM, `TIP_RST_CM, `TIP_RST_CM};
      bf_q <= {`TIP_RST_CM, `TIP_RST_CM, `TIP_RST_PERIOD, `TIP_RST_CM, `TIP_RST_CM, `TIP_RST_CM};
    end
    else
    begin
      if (xfer)
        cm_q <= bf_q;
      // stopping the timer clears the trigger compares
      if (!run)
        cm_q[59:40] <= {`TIP_RST_CM, `TIP_RST_CM};
      if (wr_fire && wstrb_q[0])
      begin
        if (aw_idx_q == `TIP_IDX_CTRL)
          ctrl_q <= wdata_q[7:0] & 8'hbf;
        if (aw_idx_q == `TIP_IDX_MODE)
          mode_q <= wdata_q[7:0] & 8'h1e;
        if (aw_idx_q == `TIP_IDX_TRGS)
          trgs_q <= wdata_q[7:0] & 8'h03;
        if (aw_idx_q == `TIP_IDX_OC)
          oc_q <= wdata_q[7:0] & 8'h03;
        // dead-time reload ignores writes while running
        if (aw_idx_q == `TIP_IDX_DTIME && !run)
          dtime_q <= wdata_q[7:0];
      end
      // trigger compares accept writes only while stopped
      if (wr_fire && wr_cm && (wr_sel < 3'h4 || !run))
        cm_q[wr_sel*10 +: 10] <= merge10(cm_q[wr_sel*10 +: 10], wdata_q, wstrb_q);
      if (wr_fire && wr_bf)
        bf_q[wr_sel*10 +: 10] <= merge10(bf_q[wr_sel*10 +: 10], wdata_q, wstrb_q);
    end
  end

  // ****************************************************************
  // phases and outputs
  // ****************************************************************
  wire [5:0] on_raw;
  wire [5:0] inhibit;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : phase
      tip_phase u_phase
      (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .cnt(cnt_q),
        .down(down_q),
        .period(period),
        .cmp(cm_q[g*10 +: 10]),
        .buf_val(bf_q[g*10 +: 10]),
        .deadtime(dtime_q),
        .pos_on(on_raw[2*g]),
        .neg_on(on_raw[2*g+1])
      );
    end
  endgenerate

  assign inhibit = (oc_q[1:0] == 2'h1) ? 6'h03 :
                   (oc_q[1:0] == 2'h2) ? 6'h0c :
                   (oc_q[1:0] == 2'h3) ? 6'h30 : 6'h00;

  wire m4 = step_q && (cnt_q == cm_q[49:40]);
  wire m5 = step_q && (cnt_q == cm_q[59:50]);

  // outputs registered; inhibited and stopped stages sit inactive
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwm_q <= 6'h3f;
      pwm_oe_q <= 1'b0;
      trig_q <= 1'b0;
      irq_q <= 1'b0;
      m4_q <= 1'b0;
      m5_q <= 1'b0;
    end
    else
    begin
      if (mode_q[`TIP_MODE_POL])
        pwm_q <= on_raw & ~inhibit & {6{run}};
      else
        pwm_q <= ~(on_raw & ~inhibit & {6{run}});
      pwm_oe_q <= run;
      irq_q <= xfer;
      m4_q <= m4;
      m5_q <= m5;
      case (trgs_q[1:0])
        `TIP_TRG_NONE: trig_q <= 1'b0;
        `TIP_TRG_A: trig_q <= m4;
        `TIP_TRG_B: trig_q <= m5;
        `TIP_TRG_AB: trig_q <= m4 || m5;
        default: trig_q <= 1'b0;
      endcase
    end
  end

  assign pwm_out = pwm_q;
  assign pwm_oe = pwm_oe_q;
  assign converter_trigger_out = trig_q;
  assign period_interrupt = irq_q;
  assign compare4_match_event = m4_q;
  assign compare5_match_event = m5_q;

endmodule

`default_nettype wire

// >>> bench/tip_stage_model.sv
`timescale 1ns/10ps
`default_nettype none

// gate drive stage: counts cycles with both switches of a leg on
module tip_stage_model
(
  // clock
  input wire logic aclk,
  // gate signals
  input wire logic [5:0] pwm_out,
  input wire logic pwm_oe,
  input wire logic active_high,
  // fault count
  output logic [7:0] shorts
);
  integer k;

  // a shorted leg would destroy a real stage, so every cycle counts until the count holds at 8'hff
  initial shorts = 8'h00;
  always @(posedge aclk)
  begin
    for (k = 0; k < 3; k++)
      if (pwm_oe && pwm_out[2*k] == active_high && pwm_out[2*k+1] == active_high
          && shorts != 8'hff)
        shorts <= shorts + 8'h01;
  end
endmodule
`default_nettype wire

// >>> bench/tip_inverter_pwm_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "tip_defs.vh"

module tip_checker
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register writes
  input wire logic [19:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  // stage and events
  input wire logic [5:0] pwm_out,
  input wire logic pwm_oe,
  input wire logic converter_trigger_out,
  input wire logic period_interrupt,
  input wire logic compare4_match_event,
  input wire logic compare5_match_event
);
  logic [19:0] aw_q;
  logic [31:0] w_q;
  logic pol_q;
  logic [5:0] act;
  logic [5:0] swp;
  logic ev;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // polarity follows the accepted mode write, so levels can be judged
  always_ff @(posedge aclk)
  begin
    if (awvalid && awready)
      aw_q <= awaddr;
    if (wvalid && wready)
      w_q <= wdata;
    if (!aresetn)
      pol_q <= 1'h0;
    else if (bvalid && bready && bresp == 2'h0 && aw_q[17:2] == `TIP_IDX_MODE)
      pol_q <= w_q[`TIP_MODE_POL];
  end

  // active view of the outputs and of each leg partner
  assign act = pol_q ? pwm_out : ~pwm_out;
  assign swp = {act[4], act[5], act[2], act[3], act[0], act[1]};
  assign ev = compare4_match_event || compare5_match_event;

  // ********
  // properties
  // ********
  sequence s_halted;
    (!pwm_oe && !bvalid)[*3];
  endsequence
  property p_halt_idle;
    s_halted |-> pwm_out == {6{~pol_q}};
  endproperty
  property p_halt_quiet;
    s_halted |-> !period_interrupt && !ev && !converter_trigger_out;
  endproperty
  property p_no_shoot;
    pwm_oe |-> (act & swp) == 6'h00;
  endproperty
  property p_dead_gap;
    pwm_oe |-> (act & ~$past(act) & $past(swp)) == 6'h00;
  endproperty
  property p_irq_once;
    period_interrupt |=> (!period_interrupt)[*3];
  endproperty
  property p_cm4_once;
    compare4_match_event |=> !compare4_match_event;
  endproperty
  property p_cm5_once;
    compare5_match_event |=> !compare5_match_event;
  endproperty
  property p_trig_cause;
    converter_trigger_out |-> ev || $past(ev) || $past(ev, 2);
  endproperty

  a_halt_idle: assert property (p_halt_idle)
    else $error("outputs not idle while stopped");
  a_halt_quiet: assert property (p_halt_quiet)
    else $error("event while stopped");
  a_no_shoot: assert property (p_no_shoot)
    else $error("both outputs of a leg active");
  a_dead_gap: assert property (p_dead_gap)
    else $error("turn-on without gap");
  a_irq_once: assert property (p_irq_once)
    else $error("period pulse too long");
  a_cm4_once: assert property (p_cm4_once)
    else $error("compare4 pulse too long");
  a_cm5_once: assert property (p_cm5_once)
    else $error("compare5 pulse too long");
  a_trig_cause: assert property (p_trig_cause)
    else $error("trigger without match");
endmodule

bind tip_inverter_pwm tip_checker chk_u
(
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
  .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .pwm_out(pwm_out),
  .pwm_oe(pwm_oe), .converter_trigger_out(converter_trigger_out),
  .period_interrupt(period_interrupt),
  .compare4_match_event(compare4_match_event),
  .compare5_match_event(compare5_match_event)
);
`default_nettype wire

// >>> bench/three_phase_inverter_pwm_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "tip_defs.vh"

module three_phase_inverter_pwm_tb;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [19:0] awaddr = 20'h0_0000;
  logic [19:0] araddr = 20'h0_0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, pwm_oe, trig, irq, ev4, ev5;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [5:0] pwm_out;
  logic [7:0] shorts;
  logic [7:0] ctl_q = 8'h00;
  logic pol = 1'h0;
  int mismatches = 0;
  int n_checks = 0;
  int P, T, D, dv;
  int c[3];

  always #50 aclk = ~aclk;

  tip_inverter_pwm dut_u
  (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .pwm_out(pwm_out),
    .pwm_oe(pwm_oe), .converter_trigger_out(trig), .period_interrupt(irq),
    .compare4_match_event(ev4), .compare5_match_event(ev5)
  );

  tip_stage_model stage_u
  (
    .aclk(aclk), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .active_high(pol),
    .shorts(shorts)
  );

  task automatic give_verdict;
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // every open-ended wait goes through here so a hang ends the run
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 60000)
    begin
      mismatches++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      tick(n);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk(bresp, er);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      tick(n);
      if (arready)
        arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(rdata, e);
    chk(rresp, er);
  endtask

  // active cycles of one output over a carrier, clamped at zero
  function automatic int wid(input int cv, input int pos);
    int w;
    if (cv > P)
      return pos ? 0 : 2 * P * T;
    w = pos ? 2 * (P - cv) * T - D - 1 : 2 * cv * T - D - 1;
    return (w < 0) ? 0 : w;
  endfunction

  task automatic setup(input int cs, input int trg, input int oc);
    int k, a;
    T = 1 << cs;
    D = 2 + $urandom % 4;
    dv = $urandom % 8;
    a = 1 + $urandom % (P - 1);
    wr(`TIP_IDX_CTRL, ctl_q & 8'h7f, 2'h0);
    ctl_q = 8'(cs * 8 + dv);
    wr(`TIP_IDX_CTRL, ctl_q, 2'h0);
    wr(`TIP_IDX_MODE, {28'h000_0000, pol, 3'h0}, 2'h0);
    wr(`TIP_IDX_TRGS, trg, 2'h0);
    wr(`TIP_IDX_OC, oc, 2'h0);
    wr(`TIP_IDX_DTIME, D, 2'h0);
    for (k = 0; k < 6; k++)
    begin
      wr(16'(`TIP_IDX_CM0 + k), k == 3 ? P : k == 4 ? a : k == 5 ? a % (P - 1) + 1 : c[k], 2'h0);
      wr(16'(`TIP_IDX_BF0 + k), k == 3 ? P : k == 4 ? a : k == 5 ? a % (P - 1) + 1 : c[k], 2'h0);
    end
    ctl_q = ctl_q | 8'h80;
    wr(`TIP_IDX_CTRL, ctl_q, 2'h0);
  endtask

  task automatic measure(input int trg, input int oc);
    int n, gap, k, nt, n4;
    int on[6] = '{default: 0};
    n = 0;
    gap = 0;
    nt = 0;
    n4 = 0;
    do tick(n); while (irq !== 1'h1);
    do tick(n); while (irq !== 1'h1);
    do
    begin
      tick(n);
      gap++;
    end
    while (irq !== 1'h1);
    chk(gap, (dv + 1) * 2 * P * T);
    repeat (2 * P * T)
    begin
      @(posedge aclk);
      for (k = 0; k < 6; k++)
        on[k] += (pwm_out[k] === pol);
      nt += (trig === 1'h1);
      n4 += (ev4 === 1'h1);
    end
    for (k = 0; k < 6; k++)
      chk(on[k], (oc != 0 && k / 2 == oc - 1) ? 0 : wid(c[k / 2], k % 2 == 0));
    chk(nt, trg == 0 ? 0 : trg == 3 ? 4 : 2);
    chk(n4, 2);
    chk(pwm_oe, 1);
  endtask

  initial
  begin
    int i, k;
    void'($urandom(47090));
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`TIP_IDX_CTRL, 0, 2'h0);
    rd(`TIP_IDX_TRGS, 0, 2'h0);
    rd(`TIP_IDX_OC, 0, 2'h0);
    rd(`TIP_IDX_DTIME, 8'hff, 2'h0);
    wr(`TIP_IDX_TRGS, 32'hffff_fff2, 2'h0);
    rd(`TIP_IDX_TRGS, 2, 2'h0);
    wr(16'hffa0, 32'h0000_00ff, 2'h2);
    rd(16'hffa0, 0, 2'h2);
    // six cases cover every clock, trigger and inhibit code
    for (i = 0; i < 6; i++)
    begin
      P = 12 + $urandom % 12;
      for (k = 0; k < 3; k++)
        c[k] = 2 + $urandom % (P - 3);
      // stop first so the stage model never judges running outputs by a new polarity
      wr(`TIP_IDX_CTRL, ctl_q & 8'h7f, 2'h0);
      @(posedge aclk);
      pol = i[0];
      setup(5 - i, i % 4, (i + 1) % 4);
      measure(i % 4, (i + 1) % 4);
    end
    // buffers changed while running: zero width and over-period hold
    c[0] = 1;
    c[2] = P + 1;
    wr(`TIP_IDX_BF0, 1, 2'h0);
    wr(16'(`TIP_IDX_BF0 + 2), P + 1, 2'h0);
    wr(`TIP_IDX_DTIME, 8'h00, 2'h0);
    rd(`TIP_IDX_DTIME, D, 2'h0);
    measure(1, 2);
    wr(`TIP_IDX_CTRL, ctl_q & 8'h7f, 2'h0);
    repeat (4) @(posedge aclk);
    chk(pwm_oe, 0);
    chk(pwm_out, {6{~pol}});
    chk(shorts, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
